// File: gpio_pins_model.sv
`timescale 1ns/1ps
// ****************************************
// Outside circuitry on one six-pin port
// ****************************************
module gpio_pins_model (
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] pullup_en,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    output logic      [5:0] pin_lvl
);
    logic [5:0] fl = 6'h2a;
    // A floating pin wanders, so a stale level never passes for a read.
    always #5 fl = ~fl;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (ext_en[i])
                pin_lvl[i] = ext_val[i];
            else if (pin_oe[i])
                pin_lvl[i] = pin_out[i];
            else if (pullup_en[i])
                pin_lvl[i] = 1'b1;
            else
                pin_lvl[i] = fl[i];
        end
    end
endmodule

// File: gpio_pkg.sv
package gpio_pkg;

    // ****************************************
    // Port geometry and register selects
    // ****************************************
    localparam int          PORT_W        = 8;
    localparam int          PIN_W         = 6;
    localparam logic [2:0]  SEL_FIRST     = 3'h6;
    localparam logic [2:0]  SEL_SECOND    = 3'h7;
    localparam int          IN_ONLY_BIT   = 3;
    localparam int          TCK_PIN_BIT   = 5;
    localparam int          OPT_WAKE_BIT  = 7;
    localparam int          OPT_PULL_BIT  = 6;
    localparam int          OPT_TCS_BIT   = 5;
    localparam logic [7:0]  OPT_RESET     = 8'hff;
    localparam logic [5:0]  DIR_RESET     = 6'h3f;
    localparam logic [5:0]  LATCH_RESET   = 6'h00;
    localparam logic [5:0]  CHG_MASK_SMALL = 6'h0b;
    localparam logic [5:0]  CHG_MASK_LARGE = 6'h1b;

    // ****************************************
    // Core access carrier
    // ****************************************
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       dir_ld;
        logic       opt_ld;
        logic [2:0] sel;
        logic [7:0] wdata;
    } core_req_s;

endpackage

// File: gpio_port.sv
`timescale 1ns/1ps
// Function
// - Port reads return synchronised pin levels, never the output latches.
// - Reset sets every direction bit so all pins start as inputs.
// - First port keeps bits 5..0; bits 7 and 6 read zero.
// - Second port exists on large variant; bits 5..0; upper bits zero.
// - First port bit 3 never drives, whatever its direction bit holds.
// - Pins given to alternate functions read as zero.
// - Bits 0,1,3 (plus 4 on large) get global pull-up and wake enables.
// - With master clear on bit 3, pull-up forced on, wake disabled.
// - Load-direction instruction copies accumulator into addressed direction register.
// - Direction one tristates the pin; zero drives the latch value.
// - Timer clock source option overrides direction of timer clock pin.
// - Direction registers are write-only and reset to all ones.
// - Output latches hold until software writes the port again.
// - Every pin, bit 3 included, has its own independent direction bit.
// - Output direction disables pull-up and wake for that pin.
// - Option bit 7 low enables wake, bit 6 low pull-ups; reset ones.
// - Read-modify-write uses pin levels and writes result to latch.
// - In sleep, wake fires when an enabled pin differs from snapshot.
module gpio_port
    import gpio_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire core_req_s         core_req,
    output logic      [PORT_W-1:0] rdata,
    input  wire logic              sleep_mode,
    output logic                   wake_event,
    input  wire logic              external_master_clear_enable,
    input  wire logic [PIN_W-1:0]  alt_func_first,
    input  wire logic [PIN_W-1:0]  alt_func_second,
    input  wire logic [PIN_W-1:0]  first_pin_in,
    output logic      [PIN_W-1:0]  first_pin_out,
    output logic      [PIN_W-1:0]  first_pin_oe,
    output logic      [PIN_W-1:0]  first_pullup_en,
    input  wire logic [PIN_W-1:0]  second_pin_in,
    output logic      [PIN_W-1:0]  second_pin_out,
    output logic      [PIN_W-1:0]  second_pin_oe
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [PIN_W-1:0] s1a_r, s2a_r, s1b_r, s2b_r;
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            s1a_r <= first_pin_in;
            s2a_r <= s1a_r;
            s1b_r <= second_pin_in;
            s2b_r <= s1b_r;
        end
    end

    function automatic logic [PORT_W-1:0] port_view(input logic [PIN_W-1:0] lvl, input logic [PIN_W-1:0] alt);
        port_view = {2'b00, lvl & ~alt};
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic [PIN_W-1:0] lat_a_r, lat_a_nxt, lat_b_r, lat_b_nxt;
    logic [PIN_W-1:0] dir_a_r, dir_a_nxt, dir_b_r, dir_b_nxt;
    logic [PORT_W-1:0] opt_r, opt_nxt, rdata_r, rdata_nxt;
    logic [PIN_W-1:0] snap_r, snap_nxt;
    logic              wake_r, wake_nxt;
    logic [PIN_W-1:0] chg_mask, chg_en;
    logic              a_acc;

    assign chg_mask = LARGE ? CHG_MASK_LARGE : CHG_MASK_SMALL;

    always_comb begin
        lat_a_nxt = lat_a_r;
        lat_b_nxt = lat_b_r;
        dir_a_nxt = dir_a_r;
        dir_b_nxt = dir_b_r;
        opt_nxt   = opt_r;
        rdata_nxt = rdata_r;
        snap_nxt  = snap_r;
        a_acc     = (core_req.rd || core_req.wr) && core_req.sel == SEL_FIRST;
        if (core_req.wr && core_req.sel == SEL_FIRST)
            lat_a_nxt = core_req.wdata[PIN_W-1:0];
        if (LARGE && core_req.wr && core_req.sel == SEL_SECOND)
            lat_b_nxt = core_req.wdata[PIN_W-1:0];
        if (core_req.dir_ld && core_req.sel == SEL_FIRST)
            dir_a_nxt = core_req.wdata[PIN_W-1:0];
        if (LARGE && core_req.dir_ld && core_req.sel == SEL_SECOND)
            dir_b_nxt = core_req.wdata[PIN_W-1:0];
        if (core_req.opt_ld)
            opt_nxt = core_req.wdata;
        if (core_req.rd) begin
            if (core_req.sel == SEL_FIRST)
                rdata_nxt = port_view(s2a_r, alt_func_first);
            else if (LARGE && core_req.sel == SEL_SECOND)
                rdata_nxt = port_view(s2b_r, alt_func_second);
            else
                rdata_nxt = 8'h00;
        end
        if (a_acc)
            snap_nxt = s2a_r;
        if (sys_rst) begin
            dir_a_nxt = DIR_RESET;
            dir_b_nxt = DIR_RESET;
            opt_nxt   = OPT_RESET;
            lat_a_nxt = LATCH_RESET;
            lat_b_nxt = LATCH_RESET;
            rdata_nxt = 8'h00;
            snap_nxt  = 6'h00;
        end
    end

    // Wake enables: global option bit, masked per pin by direction and master clear.
    always_comb begin
        chg_en = chg_mask & dir_a_r & {PIN_W{~opt_r[OPT_WAKE_BIT]}};
        if (external_master_clear_enable)
            chg_en[IN_ONLY_BIT] = 1'b0;
        wake_nxt = 1'b0;
        if (!sys_rst && sleep_mode)
            wake_nxt = |((s2a_r ^ snap_r) & chg_en);
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            lat_a_r <= lat_a_nxt;
            lat_b_r <= lat_b_nxt;
            dir_a_r <= dir_a_nxt;
            dir_b_r <= dir_b_nxt;
            opt_r   <= opt_nxt;
            rdata_r <= rdata_nxt;
            snap_r  <= snap_nxt;
            wake_r  <= wake_nxt;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // The timer pin is an input whenever the external timer clock is chosen, so a stale direction
    // bit cannot fight the clock source.
    always_comb begin
        first_pin_oe  = ~dir_a_r;
        first_pin_oe[IN_ONLY_BIT] = 1'b0;
        second_pin_oe = LARGE ? ~dir_b_r : 6'h00;
        if (LARGE && opt_r[OPT_TCS_BIT])
            second_pin_oe[TCK_PIN_BIT] = 1'b0;
        else if (!LARGE && opt_r[OPT_TCS_BIT])
            first_pin_oe[2] = 1'b0;
        first_pullup_en = chg_mask & dir_a_r & {PIN_W{~opt_r[OPT_PULL_BIT]}};
        if (external_master_clear_enable)
            first_pullup_en[IN_ONLY_BIT] = 1'b1;
    end

    assign first_pin_out  = lat_a_r;
    assign second_pin_out = LARGE ? lat_b_r : 6'h00;
    assign rdata          = rdata_r;
    assign wake_event     = wake_r;

    // ****************************************
    // Checks
    // ****************************************
    property p_in_only;
        @(posedge sys_clk) disable iff (sys_rst) !first_pin_oe[IN_ONLY_BIT];
    endproperty
    a_in_only: assert property (p_in_only) else $error("input-only pin driven");

    property p_reset_dir;
        @(posedge sys_clk) $past(sys_rst) && $past(clk_en) |-> first_pin_oe == 6'h00 && second_pin_oe == 6'h00;
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("pin driven after reset");

    property p_read_pins;
        @(posedge sys_clk) disable iff (sys_rst)
            clk_en && core_req.rd && core_req.sel == SEL_FIRST |=> rdata == port_view($past(s2a_r), $past(alt_func_first));
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("port read not pin levels");

    property p_upper_zero;
        @(posedge sys_clk) disable iff (sys_rst) rdata[7:6] == 2'b00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("unimplemented bits nonzero");

    sequence s_dir_ld_first;
        clk_en && core_req.dir_ld && core_req.sel == SEL_FIRST ##1 !opt_r[OPT_TCS_BIT];
    endsequence

    property p_dir_load;
        @(posedge sys_clk) disable iff (sys_rst)
            s_dir_ld_first |-> first_pin_oe[1:0] == ~$past(core_req.wdata[1:0]);
    endproperty
    a_dir_load: assert property (p_dir_load) else $error("direction load lost");

    property p_latch_hold;
        @(posedge sys_clk) disable iff (sys_rst)
            !(core_req.wr && core_req.sel == SEL_FIRST) || !clk_en |=> $stable(first_pin_out);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed without write");

    property p_external_master_clear_pull;
        @(posedge sys_clk) disable iff (sys_rst) external_master_clear_enable |-> first_pullup_en[IN_ONLY_BIT];
    endproperty
    a_external_master_clear_pull: assert property (p_external_master_clear_pull) else $error("master clear pull-up off");

    property p_out_no_pull;
        @(posedge sys_clk) disable iff (sys_rst) (first_pullup_en & first_pin_oe) == 6'h00;
    endproperty
    a_out_no_pull: assert property (p_out_no_pull) else $error("pull-up on output pin");

    property p_wake_sleep;
        @(posedge sys_clk) disable iff (sys_rst) wake_event |-> $past(sleep_mode);
    endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake outside sleep");

    // Without master clear a set option bit turns off every pull-up.
    property p_pull_off;
        @(posedge sys_clk) disable iff (sys_rst) opt_r[OPT_PULL_BIT] && !external_master_clear_enable |-> first_pullup_en == 6'h00;
    endproperty
    a_pull_off: assert property (p_pull_off) else $error("pull-up on while disabled");

    property p_tck_in;
        @(posedge sys_clk) disable iff (sys_rst) opt_r[OPT_TCS_BIT] |-> !second_pin_oe[TCK_PIN_BIT];
    endproperty
    a_tck_in: assert property (p_tck_in) else $error("timer clock pin driven");

endmodule

// File: gpio_port_tb.sv
`timescale 1ns/1ps
module gpio_port_tb;
    import gpio_pkg::*;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, slp = 1'b0, external_master_clear = 1'b0, ce = 1'b1, wake;
    core_req_s   req = '0;
    logic [7:0]  rdata, opt;
    logic [5:0]  a1 = 6'h00, a2 = 6'h00, i1, o1, e1, pu, i2, o2, e2, d1, d2, w1, w2;
    logic [5:0]  x1 = 6'h3f, v1 = 6'h00, x2 = 6'h3f, v2 = 6'h00;
    logic [31:0] seed = 32'h36, r, q;
    int          fails = 0, n_tests = 0;
    // ****************************************
    // Clock, design and outside circuitry
    // ****************************************
    always #2.5 sys_clk = ~sys_clk;
    gpio_port #(.LARGE(1'b1)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(ce), .core_req(req),
        .rdata(rdata), .sleep_mode(slp), .wake_event(wake), .external_master_clear_enable(external_master_clear), .alt_func_first(a1),
        .alt_func_second(a2), .first_pin_in(i1), .first_pin_out(o1), .first_pin_oe(e1),
        .first_pullup_en(pu), .second_pin_in(i2), .second_pin_out(o2), .second_pin_oe(e2));
    gpio_pins_model m1 (.pin_out(o1), .pin_oe(e1), .pullup_en(pu), .ext_en(x1), .ext_val(v1), .pin_lvl(i1));
    gpio_pins_model m2 (.pin_out(o2), .pin_oe(e2), .pullup_en(6'h00), .ext_en(x2), .ext_val(v2), .pin_lvl(i2));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [5:0] lvl(input logic [5:0] x, v, w);
        return (x & v) | (~x & w);
    endfunction
    task automatic check(input string nm, input logic [7:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask
    // Requests are raised after a falling edge and dropped one cycle later.
    // The kind bits are read, write, direction load and option load, top bit first.
    task automatic op(input logic [3:0] k, input logic [2:0] s, input logic [7:0] v);
        @(negedge sys_clk);
        req = '{k[3], k[2], k[1], k[0], s, v};
        @(negedge sys_clk);
        req = '0;
    endtask
    task automatic end_sim();
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        #100000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (4) @(negedge sys_clk);
        sys_rst = 1'b0;
        check("oe1", 8'h00, {2'b00, e1});
        check("oe2", 8'h00, {2'b00, e2});
        check("pull", 8'h00, {2'b00, pu});
        repeat (40) begin
            r = rnd();
            q = rnd();
            {opt, d1, d2, w1, w2} = r;
            {external_master_clear, a1, a2} = q[31:19];
            op(4'h1, SEL_FIRST, opt);
            op(4'h4, SEL_FIRST, {2'b11, w1});
            op(4'h4, SEL_SECOND, {2'b11, w2});
            op(4'h2, SEL_FIRST, {2'b00, d1});
            op(4'h2, SEL_SECOND, {2'b00, d2});
            op(4'h4, 3'h2, q[9:2]);
            // Outside drivers cover every pin the port leaves undriven.
            x1 = q[7:2] | d1 | 6'h08;
            x2 = q[13:8] | d2 | {opt[5], 5'h00};
            v1 = q[19:14];
            v2 = q[25:20];
            check("out1", {2'b00, w1}, {2'b00, o1});
            check("out2", {2'b00, w2}, {2'b00, o2});
            check("oe1", {2'b00, ~d1 & 6'h37}, {2'b00, e1});
            check("oe2", {2'b00, ~d2 & ~{opt[5], 5'h00}}, {2'b00, e2});
            check("pull", {2'b00, (opt[6] ? 6'h00 : CHG_MASK_LARGE & d1) | {2'b00, external_master_clear, 3'h0}},
                {2'b00, pu});
            repeat (3) @(negedge sys_clk);
            op(4'h8, SEL_FIRST, 8'h00);
            check("rd1", {2'b00, lvl(x1, v1, w1) & ~a1}, rdata);
            op(4'h8, SEL_SECOND, 8'h00);
            check("rd2", {2'b00, lvl(x2, v2, w2) & ~a2}, rdata);
            op(4'h8, 3'h2, 8'h00);
            check("rdx", 8'h00, rdata);
        end
        external_master_clear = 1'b0;
        a1 = 6'h00;
        sys_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        check("oe1", 8'h00, {2'b00, e1});
        check("oe2", 8'h00, {2'b00, e2});
        check("pull", 8'h00, {2'b00, pu});
        check("out1", 8'h00, {2'b00, o1});
        check("rd1", 8'h00, rdata);
        // With the clock enable low nothing may move, not even a direction load.
        ce = 1'b0;
        op(4'h4, SEL_FIRST, 8'h15);
        op(4'h2, SEL_FIRST, 8'h00);
        check("out1", 8'h00, {2'b00, o1});
        check("oe1", 8'h00, {2'b00, e1});
        ce = 1'b1;
        op(4'h4, SEL_FIRST, 8'h15);
        check("out1", 8'h15, {2'b00, o1});
        {x1, v1} = {6'h3f, 6'h00};
        op(4'h1, SEL_FIRST, 8'h00);
        op(4'h2, SEL_FIRST, 8'h3f);
        repeat (3) @(negedge sys_clk);
        op(4'h8, SEL_FIRST, 8'h00);
        slp = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("wake", 8'h00, {7'h0, wake});
        v1 = 6'h01;
        repeat (4) @(negedge sys_clk);
        check("wake", 8'h01, {7'h0, wake});
        v1 = 6'h00;
        external_master_clear = 1'b1;
        // The snapshot must see the settled level, so the read waits out the synchroniser.
        repeat (3) @(negedge sys_clk);
        op(4'h8, SEL_FIRST, 8'h00);
        v1 = 6'h08;
        repeat (4) @(negedge sys_clk);
        check("wake", 8'h00, {7'h0, wake});
        op(4'h1, SEL_FIRST, 8'h80);
        v1 = 6'h01;
        repeat (4) @(negedge sys_clk);
        check("wake", 8'h00, {7'h0, wake});
        end_sim();
    end
endmodule
